// >>> logic/pacc_pkg.sv
/*
 * Constants shared by the conversion control block: timing counts, widths, codes.
 * Assumes a single 20 MHz core clock; the host bus strobes are synchronous to it.
 */
// Notes on behaviour
// - write and read strobes act only while chip select is low.
// - after the flag rises the device tracks the input until a start.
// - a selected write starts hold and conversion on the strobe's rising edge.
// - the conversion steps through all bits by itself from the conversion clock.
// - at the end the result is latched and the completion flag goes low.
// - a selected read drives the latched result and raises the flag again.
// - a conversion completes within 6 microseconds.
// - out-of-range inputs saturate to all ones or all zeros.
package pacc_pkg;
    localparam int unsigned DATA_W        = 10;
    localparam int unsigned CORE_HZ       = 20_000_000;
    localparam int unsigned CONV_CLK_HZ   = 4_200_000;
    // conversion clock enable divider: 20 MHz / 4 = 5 MHz, at least the 4.2 MHz figure
    localparam int unsigned CONV_DIV      = CORE_HZ / 5_000_000;
    localparam int unsigned CONV_TIME_US  = 6;
    // longest conversion time rounded down to whole core cycles
    localparam int unsigned CONV_MAX_CYC  = CONV_TIME_US * (CORE_HZ / 1_000_000);
    localparam logic [DATA_W-1:0] CODE_MAX = 10'h3FF;
    localparam logic [DATA_W-1:0] CODE_MIN = 10'h000;
    localparam logic [DATA_W-1:0] RESULT_RST = 10'h000;
endpackage

// >>> logic/pacc_sar.sv
/*
 * Successive-approximation sequencer: one bit decided per conversion clock enable.
 * Assumes the comparator answers for the current trial code in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module pacc_sar
    import pacc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              start,
    input  wire logic              step_en,
    input  wire logic              cmp_above,
    output logic [DATA_W-1:0]      trial_code,
    output logic                   busy,
    output logic                   done,
    output logic [DATA_W-1:0]      result
);
    typedef struct packed {
        logic [DATA_W-1:0] code;
        logic [DATA_W-1:0] bitm;
        logic              busy;
        logic              done;
    } pacc_sar_type;
    pacc_sar_type s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.bitm = {1'b1, {(DATA_W-1){1'b0}}};
            s_d.code = {1'b1, {(DATA_W-1){1'b0}}};
        end else if (s_q.busy && step_en) begin
            // comparator says input below trial: drop this bit
            if (!cmp_above) begin
                s_d.code = s_q.code & ~s_q.bitm;
            end
            s_d.bitm = s_q.bitm >> 1;
            if (s_q.bitm[0]) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.code = s_d.code | (s_q.bitm >> 1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign trial_code = s_q.code;
    assign busy       = s_q.busy;
    assign done       = s_q.done;
    // above full scale every bit is kept, below zero every bit is dropped
    assign result     = s_q.code;
endmodule // pacc_sar
`default_nettype wire

// >>> logic/pacc_conv_ctrl.sv
/*
 * Conversion control of a parallel-port 10-bit converter: host strobes, hold,
 * sequencing, output latch, completion flag and the three-state data pins.
 * Assumes the host strobes are synchronous to core_clk and the comparator is external.
 */
`timescale 1ns/1ps
`default_nettype none
module pacc_conv_ctrl
    import pacc_pkg::*;
#(
    parameter int unsigned DIV = CONV_DIV
) (
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    input  wire logic                      cs_n,
    input  wire logic                      wr_n,
    input  wire logic                      rd_n,
    input  wire logic                      cmp_above,
    output logic                           track,
    output logic [pacc_pkg::DATA_W-1:0]    trial_code,
    output logic                           eoc_n,
    output logic [pacc_pkg::DATA_W-1:0]    data_out,
    output logic                           data_oe
);
    typedef enum logic [2:0] {
        ST_TRACK = 3'b001,
        ST_CONV  = 3'b010,
        ST_READY = 3'b100
    } pacc_state_type;

    typedef struct packed {
        pacc_state_type    st;
        logic              wr_n_p;
        logic [7:0]        div;
        logic [DATA_W-1:0] latch;
        logic              eoc_n;
    } pacc_ctrl_type;
    pacc_ctrl_type r_q, r_d;

    logic              wr_sel;
    logic              rd_sel;
    logic              wr_rise;
    logic              step_en;
    logic              sar_busy;
    logic              sar_done;
    logic [DATA_W-1:0] sar_result;

    assign wr_sel  = !cs_n && !wr_n;
    assign rd_sel  = !cs_n && !rd_n;
    // rising edge of a write that was low while selected
    assign wr_rise = !r_q.wr_n_p && wr_n && !cs_n;
    assign step_en = (r_q.div == 8'(DIV - 1));

    pacc_sar u_sar (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .start      (wr_rise && r_q.st != ST_CONV),
        .step_en    (step_en),
        .cmp_above  (cmp_above),
        .trial_code (trial_code),
        .busy       (sar_busy),
        .done       (sar_done),
        .result     (sar_result)
    );

    always_comb begin
        r_d = r_q;
        r_d.wr_n_p = wr_n | cs_n;
        r_d.div = (step_en || r_q.st != ST_CONV) ? 8'h00 : r_q.div + 8'h01;
        case (r_q.st)
            ST_TRACK, ST_READY: begin
                if (wr_rise) begin
                    r_d.st = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    r_d.latch = sar_result;
                    r_d.eoc_n = 1'b0;
                    r_d.st    = ST_READY;
                end
            end
            default: r_d.st = ST_TRACK;
        endcase
        // a read raises the flag; a same-cycle completion keeps it low
        if (rd_sel && !(r_q.st == ST_CONV && sar_done)) begin
            r_d.eoc_n = 1'b1;
        end
        if (r_d.eoc_n && !r_q.eoc_n && r_d.st == ST_READY) begin
            r_d.st = ST_TRACK;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_q.st     <= ST_TRACK;
            r_q.wr_n_p <= 1'b1;
            r_q.div    <= 8'h00;
            r_q.latch  <= RESULT_RST;
            r_q.eoc_n  <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // tracking whenever not holding for a conversion
    assign track    = (r_q.st != ST_CONV);
    assign eoc_n    = r_q.eoc_n;
    assign data_out = r_q.latch;
    // pins released unless a selected read is under way
    assign data_oe  = rd_sel;

    // conversion length counter for checking
    logic [7:0] conv_cyc_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_cyc_q <= 8'h00;
        end else if (r_q.st == ST_CONV) begin
            conv_cyc_q <= conv_cyc_q + 8'h01;
        end else begin
            conv_cyc_q <= 8'h00;
        end
    end

    // comparator answers seen during the current conversion, for the saturation checks
    logic all_above_q;
    logic all_below_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            all_above_q <= 1'b0;
            all_below_q <= 1'b0;
        end else if (wr_rise && r_q.st != ST_CONV) begin
            all_above_q <= 1'b1;
            all_below_q <= 1'b1;
        end else if (sar_busy && step_en) begin
            if (!cmp_above) begin
                all_above_q <= 1'b0;
            end
            if (cmp_above) begin
                all_below_q <= 1'b0;
            end
        end
    end

    property p_oe_only_selected;
        @(posedge core_clk) disable iff (sys_rst) data_oe |-> (!cs_n && !rd_n);
    endproperty
    a_oe_only_selected: assert property (p_oe_only_selected)
        else $error("data pins driven outside a selected read");

    property p_unselected_no_start;
        @(posedge core_clk) disable iff (sys_rst)
            (r_q.st == ST_TRACK && cs_n) |=> (r_q.st == ST_TRACK);
    endproperty
    a_unselected_no_start: assert property (p_unselected_no_start)
        else $error("conversion started while not selected");

    property p_start_on_rise;
        @(posedge core_clk) disable iff (sys_rst)
            (r_q.st == ST_TRACK && wr_rise) |=> (r_q.st == ST_CONV && !track);
    endproperty
    a_start_on_rise: assert property (p_start_on_rise)
        else $error("write rising edge did not start hold");

    property p_track_until_start;
        @(posedge core_clk) disable iff (sys_rst)
            $rose(eoc_n) |-> track;
    endproperty
    a_track_until_start: assert property (p_track_until_start)
        else $error("not tracking after flag rose");

    property p_conv_time;
        @(posedge core_clk) disable iff (sys_rst)
            conv_cyc_q <= 8'(CONV_MAX_CYC);
    endproperty
    a_conv_time: assert property (p_conv_time)
        else $error("conversion exceeded its time limit");

    property p_done_latches;
        @(posedge core_clk) disable iff (sys_rst)
            (r_q.st == ST_CONV && sar_done) |=> (!eoc_n && data_out == $past(sar_result));
    endproperty
    a_done_latches: assert property (p_done_latches)
        else $error("result not latched or flag not lowered");

    property p_read_raises;
        @(posedge core_clk) disable iff (sys_rst)
            (rd_sel && r_q.st == ST_READY) |=> eoc_n;
    endproperty
    a_read_raises: assert property (p_read_raises)
        else $error("read did not raise the completion flag");

    property p_sar_self_runs;
        @(posedge core_clk) disable iff (sys_rst)
            $rose(sar_busy) |-> ##[39:41] sar_done;
    endproperty
    a_sar_self_runs: assert property (p_sar_self_runs)
        else $error("conversion did not finish on its own");

    property p_saturate_high;
        @(posedge core_clk) disable iff (sys_rst)
            (sar_done && all_above_q) |-> (sar_result == CODE_MAX);
    endproperty
    a_saturate_high: assert property (p_saturate_high)
        else $error("full scale input did not give all ones");

    property p_saturate_low;
        @(posedge core_clk) disable iff (sys_rst)
            (sar_done && all_below_q) |-> (sar_result == CODE_MIN);
    endproperty
    a_saturate_low: assert property (p_saturate_low)
        else $error("input below zero did not give all zeros");

    // the first trial of every conversion is the most significant bit alone
    property p_msb_first;
        @(posedge core_clk) disable iff (sys_rst)
            $rose(sar_busy) |-> (trial_code == {1'b1, {(DATA_W-1){1'b0}}});
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("conversion did not begin with the top bit");

    c_start: cover property (@(posedge core_clk) wr_rise);
    c_done:  cover property (@(posedge core_clk) $fell(eoc_n));
    c_read:  cover property (@(posedge core_clk) rd_sel && !eoc_n);
    c_sat_high: cover property (@(posedge core_clk) sar_done && all_above_q);
    c_sat_low:  cover property (@(posedge core_clk) sar_done && all_below_q);
endmodule // pacc_conv_ctrl
`default_nettype wire

// >>> dv/pacc_cmp_model.sv
/*
 * Analog front end model: sample-and-hold plus comparator facing the sequencer.
 * Assumes track high means sampling and trial_code is registered in the block.
 */
`timescale 1ns/1ps
`default_nettype none
module pacc_cmp_model
    import pacc_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   track,
    input  wire logic [pacc_pkg::DATA_W-1:0] trial_code,
    input  var  int                     vin,
    output logic                        cmp_above
);
    int held = 0;
    // the input is followed only while tracking; hold freezes it
    always @(posedge core_clk) if (track) held <= vin;
    // levels beyond either reference compare one way on every trial
    assign cmp_above = held >= int'(trial_code);
endmodule // pacc_cmp_model
`default_nettype wire

// >>> dv/parallel_adc_conversion_control_test.sv
/*
 * Self-checking bench of the conversion control block with an analog model.
 * Assumes the host strobes change at the falling edge of core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module parallel_adc_conversion_control_test;
    import pacc_pkg::*;
    logic              core_clk, sys_rst, cs_n, wr_n, rd_n, cmp_above;
    logic              track, eoc_n, data_oe;
    logic [DATA_W-1:0] trial_code, data_out;
    wire  [DATA_W-1:0] data_bus;
    int                vin, failures, tests_run, cycles;

    // released bus floats, as a host would see it
    assign data_bus = data_oe ? data_out : 'z;

    pacc_conv_ctrl #(.DIV(CONV_DIV)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .cmp_above(cmp_above), .track(track),
        .trial_code(trial_code), .eoc_n(eoc_n), .data_out(data_out), .data_oe(data_oe));
    pacc_cmp_model afe (.core_clk(core_clk), .track(track), .trial_code(trial_code),
        .vin(vin), .cmp_above(cmp_above));

    initial begin
        core_clk = 0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a whole conversion, optionally with a write poked in mid-way, then a read
    task automatic convert(input int v0, input int v1, input logic [DATA_W-1:0] exp,
                           input bit poke);
        int n;
        n = 1;
        vin = v0;
        @(negedge core_clk); cs_n = 0; wr_n = 0;
        @(negedge core_clk); wr_n = 1;
        @(negedge core_clk); cs_n = 1;
        vin = v1;
        while (eoc_n !== 1'b0 && n < 200) begin
            @(negedge core_clk);
            n++;
            if (n == 2) check(track, 1'b0);
            if (n == 2) check(trial_code, 10'h200);
            if (poke && n == 10) begin cs_n = 0; wr_n = 0; end
            if (poke && n == 12) wr_n = 1;
            if (poke && n == 13) cs_n = 1;
        end
        check(n >= 40 && n <= 45, 1);
        check(track, 1'b1);
        check(data_out, exp);
        rd_n = 0;
        @(negedge core_clk);
        check(eoc_n, 1'b0);
        check(data_oe, 1'b0);
        cs_n = 0;
        #1 check(data_bus, exp);
        @(negedge core_clk);
        check(eoc_n, 1'b1);
        cs_n = 1;
        rd_n = 1;
        #1 check(data_oe, 1'b0);
    endtask

    // strobes with chip select high must leave the device untouched
    task automatic unselected();
        @(negedge core_clk); wr_n = 0; rd_n = 0;
        #1 check(data_oe, 1'b0);
        @(negedge core_clk); wr_n = 1;
        repeat (3) @(negedge core_clk);
        check(track, 1'b1);
        check(eoc_n, 1'b1);
        rd_n = 1;
    endtask

    // reset in the middle of a conversion must abandon it and leave the device idle
    task automatic reset_mid();
        @(negedge core_clk); cs_n = 0; wr_n = 0;
        @(negedge core_clk); wr_n = 1;
        @(negedge core_clk); cs_n = 1;
        repeat (10) @(negedge core_clk);
        check(track, 1'b0);
        sys_rst = 1;
        repeat (2) @(negedge core_clk);
        check(track, 1'b1);
        check(eoc_n, 1'b1);
        check(trial_code, 10'h000);
        check(data_out, RESULT_RST);
        sys_rst = 0;
        repeat (60) @(negedge core_clk);
        check(eoc_n, 1'b1);
        check(track, 1'b1);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        sys_rst = 1; cs_n = 1; wr_n = 1; rd_n = 1;
        vin = 0; failures = 0; tests_run = 0; cycles = 0;
        repeat (20) @(negedge core_clk);
        check(track, 1'b1);
        check(eoc_n, 1'b1);
        check(data_out, RESULT_RST);
        sys_rst = 0;
        unselected();
        convert(341, 100, 10'h155, 0);
        convert(2000, 5, CODE_MAX, 1);
        convert(-7, 900, CODE_MIN, 0);
        convert(512, 0, 10'h200, 0);
        reset_mid();
        convert(1, 1023, 10'h001, 0);
        give_verdict();
    end
endmodule // parallel_adc_conversion_control_test
`default_nettype wire
